// ==== fcmd_pkg.sv ====
package fcmd_pkg;

  localparam int MCLK_PS = 4000;

  // Flash bus timing, in the unit in which each figure is given.
  localparam int T_WE_LOW_NS   = 35;
  localparam int T_WE_HIGH_NS  = 30;
  localparam int T_ACCESS_NS   = 70;
  localparam int T_RESET_NS    = 500;
  localparam int T_SETTLE_NS   = 200;
  localparam int T_WINDOW_US   = 50;
  localparam int T_SUSPEND_US  = 20;

  // Least times round up, the window (a longest time) rounds down.
  localparam int WE_LOW_CYC   = (T_WE_LOW_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int WE_HIGH_CYC  = (T_WE_HIGH_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int ACCESS_CYC   = (T_ACCESS_NS * 1000 + MCLK_PS - 1) / MCLK_PS + 3;
  localparam int RESET_CYC    = (T_RESET_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int SETTLE_CYC   = (T_SETTLE_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int WINDOW_CYC   = (T_WINDOW_US * 1000000) / MCLK_PS;
  localparam int SUSPEND_CYC  = (T_SUSPEND_US * 1000000 + MCLK_PS - 1) / MCLK_PS;
  localparam int ADD_MARGIN   = WE_LOW_CYC + 4;

  // Software register offsets.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam logic [3:0] REG_RDATA  = 4'h0;

  // Operations written to the control register.
  localparam logic [3:0] OP_READ     = 4'h0;
  localparam logic [3:0] OP_PROGRAM  = 4'h1;
  localparam logic [3:0] OP_BYP_ENT  = 4'h2;
  localparam logic [3:0] OP_BYP_PROG = 4'h3;
  localparam logic [3:0] OP_BYP_EXIT = 4'h4;
  localparam logic [3:0] OP_CHIP_ER  = 4'h5;
  localparam logic [3:0] OP_SECT_ER  = 4'h6;
  localparam logic [3:0] OP_SECT_ADD = 4'h7;
  localparam logic [3:0] OP_SUSPEND  = 4'h8;
  localparam logic [3:0] OP_RESUME   = 4'h9;
  localparam logic [3:0] OP_RESET    = 4'ha;
  localparam logic [3:0] OP_HWRESET  = 4'hb;

  // Command addresses and codes in word mode.
  localparam logic [19:0] A_UNLOCK1 = 20'h00555;
  localparam logic [19:0] A_UNLOCK2 = 20'h002aa;
  localparam logic [19:0] A_ANY     = 20'h00000;
  localparam logic [15:0] D_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] D_PROGRAM = 16'h00a0;
  localparam logic [15:0] D_BYPASS  = 16'h0020;
  localparam logic [15:0] D_BYP_EX1 = 16'h0090;
  localparam logic [15:0] D_BYP_EX2 = 16'h0000;
  localparam logic [15:0] D_ERASE   = 16'h0080;
  localparam logic [15:0] D_CHIP    = 16'h0010;
  localparam logic [15:0] D_SECTOR  = 16'h0030;
  localparam logic [15:0] D_SUSPEND = 16'h00b0;
  localparam logic [15:0] D_RESUME  = 16'h0030;
  localparam logic [15:0] D_RESET   = 16'h00f0;
  localparam int SECT_HI = 19;
  localparam int SECT_LO = 12;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dq;
    logic        dqOe;
    logic        ceN;
    logic        weN;
    logic        oeN;
    logic        resetN;
  } fcmd_pins_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fcmd_cycle_t;

endpackage

// ==== fcmd_sync.sv ====
`timescale 1ns/100ps
module fcmd_sync import fcmd_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // A bit changes only once the second and third stages agree.
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        s1_q[i] <= 1'b1;
        s2_q[i] <= 1'b1;
        s3_q[i] <= 1'b1;
        dout[i] <= 1'b1;
      end
      else
      begin
        s1_q[i] <= din[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i])
          dout[i] <= s3_q[i];
      end
    end
  end

endmodule

// ==== fcmd_host.sv ====
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - Program is two unlock writes, set-up write, then address and data.
// - Hardware reset aborts programming; software must reissue the program afterwards.
// - Bypass entry is two unlock writes then the bypass code.
// - Bypass program is the program code then address and data, repeated.
// - Bypass exit writes the exit code then zero at any address.
// - Chip erase is six writes ending in the chip erase code.
// - Sector erase is six writes ending in sector address and sector code.
// - A 50 us window after the last write rise accepts more sectors.
// - The host keeps each extra sector write inside the window.
// - Unlock writes AA at 555 and 55 at 2AA; program code A0.
module fcmd_host import fcmd_pkg::*;
#(
  parameter int WIN_CYC  = WINDOW_CYC,
  parameter int SUSP_CYC = SUSPEND_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  output fcmd_pins_t       flashPins,
  input  wire logic [15:0] flashDqIn,
  input  wire logic        readyBusy
);

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_SETUP  = 7'b0000010,
    ST_STROBE = 7'b0000100,
    ST_HOLD   = 7'b0001000,
    ST_READ   = 7'b0010000,
    ST_WAIT   = 7'b0100000,
    ST_HWRST  = 7'b1000000
  } fcmd_state_t;

  fcmd_state_t state_q;
  fcmd_state_t state_d;
  logic [3:0]  op_q;
  logic [19:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] rdData_q;
  logic [2:0]  idx_q;
  logic [15:0] timer_q;
  logic [15:0] timer_d;
  logic [15:0] window_q;
  logic        bypass_q;
  logic        sectErase_q;
  logic        suspended_q;
  logic        refused_q;
  logic        resetAbort_q;
  fcmd_pins_t  pins_d;
  logic        readyLvl;
  logic [15:0] dqSync;

  fcmd_sync #(.W(1)) u_rdySync
  (
    .mclk  (mclk),
    .reset (reset),
    .din   (readyBusy),
    .dout  (readyLvl)
  );

  fcmd_sync #(.W(16)) u_dqSync
  (
    .mclk  (mclk),
    .reset (reset),
    .din   (flashDqIn),
    .dout  (dqSync)
  );

  // Bus cycle sequence of each operation.
  function automatic fcmd_cycle_t seqCycle(input logic [3:0] op, input logic [2:0] idx,
                                           input logic [19:0] a, input logic [15:0] d);
    fcmd_cycle_t c;
    c = '{addr: A_ANY, data: D_RESET};
    case (op)
      OP_BYP_PROG: c = (idx == 3'h0) ? fcmd_cycle_t'{A_ANY, D_PROGRAM} : fcmd_cycle_t'{a, d};
      OP_BYP_EXIT: c = (idx == 3'h0) ? fcmd_cycle_t'{A_ANY, D_BYP_EX1}
                                     : fcmd_cycle_t'{A_ANY, D_BYP_EX2};
      OP_SECT_ADD: c = '{{a[SECT_HI:SECT_LO], 12'h000}, D_SECTOR};
      OP_SUSPEND:  c = '{A_ANY, D_SUSPEND};
      OP_RESUME:   c = '{A_ANY, D_RESUME};
      OP_RESET:    c = '{A_ANY, D_RESET};
      default:
        case (idx)
          3'h0, 3'h3:
            c = (op == OP_PROGRAM && idx == 3'h3) ? fcmd_cycle_t'{a, d}
                                                  : fcmd_cycle_t'{A_UNLOCK1, D_UNLOCK1};
          3'h1, 3'h4: c = '{A_UNLOCK2, D_UNLOCK2};
          3'h2:
            case (op)
              OP_PROGRAM: c = '{A_UNLOCK1, D_PROGRAM};
              OP_BYP_ENT: c = '{A_UNLOCK1, D_BYPASS};
              default:    c = '{A_UNLOCK1, D_ERASE};
            endcase
          default:
            case (op)
              OP_CHIP_ER: c = '{A_UNLOCK1, D_CHIP};
              default:    c = '{{a[SECT_HI:SECT_LO], 12'h000}, D_SECTOR};
            endcase
        endcase
    endcase
    return c;
  endfunction

  function automatic logic [2:0] seqLast(input logic [3:0] op);
    case (op)
      OP_PROGRAM:               return 3'h3;
      OP_BYP_ENT:               return 3'h2;
      OP_BYP_PROG, OP_BYP_EXIT: return 3'h1;
      OP_CHIP_ER, OP_SECT_ER:   return 3'h5;
      default:                  return 3'h0;
    endcase
  endfunction

  wire [3:0]  reqOp      = regWdata[3:0];
  wire        ctrlWrite  = regWrite && (regAddr == REG_CTRL);
  wire        statWrite  = regWrite && (regAddr == REG_STATUS);
  wire        windowOpen = (window_q != 16'h0000);
  wire        devBusy    = !readyLvl && !suspended_q;
  wire        engIdle    = (state_q == ST_IDLE);
  wire        isErase    = (reqOp == OP_CHIP_ER) || (reqOp == OP_SECT_ER) || (reqOp == OP_BYP_ENT);
  wire        isBypOp    = (reqOp == OP_BYP_PROG) || (reqOp == OP_BYP_EXIT);
  // A partial or mixed sequence would silently drop the device back to array read, so it is never issued.
  wire        reqLegal   = (reqOp == OP_HWRESET) ? 1'b1 :
                           (reqOp == OP_SUSPEND) ? (sectErase_q && !suspended_q) :
                           (reqOp == OP_SECT_ADD) ? (window_q > 16'(ADD_MARGIN)) :
                           (reqOp == OP_RESUME) ? suspended_q :
                           (reqOp > OP_HWRESET) ? 1'b0 :
                           windowOpen ? 1'b0 :
                           devBusy ? 1'b0 :
                           bypass_q ? isBypOp :
                           isBypOp ? 1'b0 :
                           suspended_q ? !isErase : 1'b1;
  wire        accept     = ctrlWrite && engIdle && reqLegal;
  wire        timerDone  = (timer_q == 16'h0000);
  wire        lastCyc    = (idx_q == seqLast(op_q));
  // The pins are registered from the next state, so they must carry the next cycle's address and data as well.
  wire [3:0]  opNext     = accept ? reqOp : op_q;
  wire [2:0]  idxNext    = accept ? 3'h0 : ((state_q == ST_HOLD) && timerDone && !lastCyc) ? idx_q + 3'h1 : idx_q;
  wire fcmd_cycle_t cur  = seqCycle(opNext, idxNext, addr_q, data_q);
  wire        weRise     = (state_q == ST_STROBE) && timerDone;
  wire        winStart   = weRise && lastCyc && ((op_q == OP_SECT_ER) || (op_q == OP_SECT_ADD));
  wire        finish     = (state_q == ST_HOLD) && timerDone && lastCyc;

  always_comb
  begin
    state_d = state_q;
    timer_d = timerDone ? 16'h0000 : timer_q - 16'h0001;
    case (state_q)
      ST_IDLE:
        if (accept)
        begin
          timer_d = (reqOp == OP_READ) ? 16'(ACCESS_CYC) : 16'(RESET_CYC);
          state_d = (reqOp == OP_READ) ? ST_READ : (reqOp == OP_HWRESET) ? ST_HWRST : ST_SETUP;
        end
      ST_SETUP:
      begin
        timer_d = 16'(WE_LOW_CYC - 1);
        state_d = ST_STROBE;
      end
      ST_STROBE:
        if (timerDone)
        begin
          timer_d = 16'(WE_HIGH_CYC - 1);
          state_d = ST_HOLD;
        end
      ST_HOLD:
        if (timerDone)
        begin
          // Accepting a suspend has already cleared the window, so every suspend waits the full suspend time here.
          timer_d = (op_q == OP_SUSPEND && !windowOpen) ? 16'(SUSP_CYC) : 16'(SETTLE_CYC);
          state_d = lastCyc ? ST_WAIT : ST_SETUP;
        end
      ST_READ, ST_HWRST:
        if (timerDone)
        begin
          timer_d = 16'(SETTLE_CYC);
          state_d = (state_q == ST_READ) ? ST_IDLE : ST_WAIT;
        end
      ST_WAIT:
        if (timerDone)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_comb
  begin
    pins_d        = '{addr: cur.addr, dq: cur.data, dqOe: 1'b0, ceN: 1'b1, weN: 1'b1, oeN: 1'b1, resetN: 1'b1};
    pins_d.dqOe   = (state_d == ST_SETUP) || (state_d == ST_STROBE) || (state_d == ST_HOLD);
    pins_d.ceN    = !(pins_d.dqOe || (state_d == ST_READ));
    pins_d.weN    = (state_d != ST_STROBE);
    pins_d.oeN    = (state_d != ST_READ);
    pins_d.resetN = (state_d != ST_HWRST);
    if (state_d == ST_READ)
      pins_d.addr = addr_q;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q   <= ST_IDLE;
      timer_q   <= 16'h0000;
      flashPins <= '{addr: 20'h00000, dq: 16'h0000, dqOe: 1'b0, ceN: 1'b1, weN: 1'b1, oeN: 1'b1, resetN: 1'b1};
    end
    else
    begin
      state_q   <= state_d;
      timer_q   <= timer_d;
      flashPins <= pins_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      op_q     <= OP_READ;
      addr_q   <= 20'h00000;
      data_q   <= 16'h0000;
      idx_q    <= 3'h0;
      rdData_q <= 16'h0000;
      regRdata <= 32'h00000000;
    end
    else
    begin
      if (accept)
        op_q <= reqOp;
      if (regWrite && regAddr == REG_ADDR && engIdle)
        addr_q <= regWdata[19:0];
      if (regWrite && regAddr == REG_DATA && engIdle)
        data_q <= regWdata[15:0];
      if (accept)
        idx_q <= 3'h0;
      else if ((state_q == ST_HOLD) && timerDone && !lastCyc)
        idx_q <= idx_q + 3'h1;
      if ((state_q == ST_READ) && timerDone)
        rdData_q <= dqSync;
      regRdata <= !regRead ? 32'h00000000 :
                  (regAddr == REG_STATUS) ? {24'h000000, resetAbort_q, refused_q, sectErase_q, windowOpen,
                                             suspended_q, bypass_q, readyLvl, !engIdle} :
                  (regAddr == REG_RDATA) ? {16'h0000, rdData_q} : 32'h00000000;
    end
  end

  // Mode tracking mirrors the device's command state so illegal requests never reach the pins.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      window_q     <= 16'h0000;
      bypass_q     <= 1'b0;
      sectErase_q  <= 1'b0;
      suspended_q  <= 1'b0;
      refused_q    <= 1'b0;
      resetAbort_q <= 1'b0;
    end
    else
    begin
      if (winStart)
        window_q <= 16'(WIN_CYC);
      else if (accept && (reqOp == OP_SUSPEND || reqOp == OP_HWRESET))
        window_q <= 16'h0000;
      else if (windowOpen)
        window_q <= window_q - 16'h0001;
      if (finish && op_q == OP_BYP_ENT)
        bypass_q <= 1'b1;
      else if ((finish && op_q == OP_BYP_EXIT) || (accept && reqOp == OP_HWRESET))
        bypass_q <= 1'b0;
      if (finish && op_q == OP_SECT_ER)
        sectErase_q <= 1'b1;
      else if ((accept && reqOp == OP_HWRESET) || (engIdle && !windowOpen && !suspended_q && readyLvl))
        sectErase_q <= 1'b0;
      if (finish && op_q == OP_SUSPEND)
        suspended_q <= 1'b1;
      else if ((finish && op_q == OP_RESUME) || (accept && reqOp == OP_HWRESET))
        suspended_q <= 1'b0;
      // A new event wins over a software clear in the same cycle.
      if (ctrlWrite && !accept)
        refused_q <= 1'b1;
      else if (statWrite && regWdata[6])
        refused_q <= 1'b0;
      if (accept && reqOp == OP_HWRESET && !readyLvl)
        resetAbort_q <= 1'b1;
      else if (statWrite && regWdata[7])
        resetAbort_q <= 1'b0;
    end
  end

endmodule

// ==== fcmd_host_checker.sv ====
`timescale 1ns/100ps
module fcmd_host_checker import fcmd_pkg::*;
#(
  parameter int WIN_CYC  = WINDOW_CYC,
  parameter int SUSP_CYC = SUSPEND_CYC
)
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire fcmd_pins_t  flashPins,
  input wire logic [15:0] flashDqIn,
  input wire logic        readyBusy
);
  logic [7:0] rstCnt_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Counts the low time of the flash reset pin, so its full width can be judged at the rising edge.
  always_ff @(posedge mclk)
  begin
    rstCnt_q <= (reset || flashPins.resetN) ? 8'h00 : rstCnt_q + 8'h01;
  end
  sequence sStrobe;
    (!flashPins.weN)[*8];
  endsequence
  sequence sHold;
    (flashPins.weN && !flashPins.ceN && flashPins.dqOe)[*8];
  endsequence
  rd_zero_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  strobe_len_a: assert property ($fell(flashPins.weN) |-> ##1 sStrobe ##1 flashPins.weN)
    else $error("write strobe not nine cycles low");
  hold_len_a: assert property ($rose(flashPins.weN) |-> sHold)
    else $error("write hold shorter than eight cycles");
  setup_a: assert property ($fell(flashPins.weN) |-> !$past(flashPins.ceN) && $stable(flashPins.addr))
    else $error("write strobe without setup cycle");
  strobe_stable_a: assert property (!flashPins.weN && !$past(flashPins.weN)
    |-> $stable(flashPins.addr) && $stable(flashPins.dq) && flashPins.dqOe)
    else $error("address or data moved during strobe");
  no_clash_a: assert property (!flashPins.oeN |-> !flashPins.dqOe && flashPins.weN && !flashPins.ceN)
    else $error("host drives data while device outputs");
  rst_width_a: assert property ($rose(flashPins.resetN) |-> rstCnt_q == 8'(RESET_CYC + 1))
    else $error("hardware reset pulse width wrong");
  rst_quiet_a: assert property (!flashPins.resetN |-> flashPins.weN && flashPins.ceN && flashPins.oeN)
    else $error("bus cycle during hardware reset");
endmodule

bind fcmd_host fcmd_host_checker #(.WIN_CYC(WIN_CYC), .SUSP_CYC(SUSP_CYC)) fcmd_host_checker_inst (
  .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .flashPins(flashPins), .flashDqIn(flashDqIn),
  .readyBusy(readyBusy));

// ==== fcmd_flash.sv ====
`timescale 1ns/100ps
module fcmd_flash import fcmd_pkg::*;
#(
  parameter int WIN = 200
)
(
  input  wire logic       mclk,
  input  wire fcmd_pins_t pins,
  output logic [15:0]     dqOut,
  output logic            readyBusy
);
  logic [15:0]  mem [4096] = '{default: 16'hffff};
  logic [255:0] sel = '0;
  logic [3:0]   st = 4'h0;
  logic         susp = 1'b0;
  logic         weQ = 1'b1;
  logic [15:0]  drv_q = 16'h0;
  int           busy = 0;
  int           win = 0;
  int           ers = 0;
  wire [19:0]   a = pins.addr;
  wire [15:0]   d = pins.dq;
  wire [11:0]   ix = {a[19:12], a[3:0]};
  wire          wr = pins.weN && !weQ && !pins.ceN;
  assign dqOut = drv_q;
  assign readyBusy = !(busy > 0 || win > 0 || (ers > 0 && !susp));
  always @(posedge mclk)
  begin
    weQ <= pins.weN;
    // Released lines toggle so a late sample never looks like good data.
    drv_q <= (!pins.ceN && !pins.oeN) ? mem[ix] : ~drv_q;
    if (busy > 0) busy <= busy - 1;
    if (win > 0) win <= win - 1;
    if (win == 1) st <= 4'h0;
    if (win == 1) ers <= 150;
    if (ers > 0 && win == 0 && !susp) ers <= ers - 1;
    if (ers == 1 && !susp) foreach (mem[i]) if (sel[i[11:4]]) mem[i] = 16'hffff;
    if (ers == 1 && !susp) sel = '0;
    if (wr && busy == 0 && (ers == 0 || susp || win > 0 || d == 16'h00b0))
    begin
      case (st)
        4'h0:
        begin
          st <= (a == 20'h00555 && d == 16'h00aa) ? 4'h1 : 4'h0;
          if (d == 16'h00b0 && ers > 0) susp <= 1'b1;
          if (d == 16'h0030 && susp) susp <= 1'b0;
        end
        4'h1, 4'h5: st <= (a == 20'h002aa && d == 16'h0055) ? st + 4'h1 : 4'h0;
        4'h2:
          st <= a != 20'h00555 ? 4'h0 : d == 16'h00a0 ? 4'h3 : d == 16'h0020 ? 4'h8 : d == 16'h0080 ? 4'h4 : 4'h0;
        4'h4: st <= (a == 20'h00555 && d == 16'h00aa) ? 4'h5 : 4'h0;
        4'h3, 4'h9:
        begin
          mem[ix] = mem[ix] & d;
          busy <= 100;
          st <= st == 4'h9 ? 4'h8 : 4'h0;
        end
        4'h6:
        begin
          st <= d == 16'h0030 ? 4'h7 : 4'h0;
          if (d == 16'h0030) sel[a[19:12]] = 1'b1;
          win <= d == 16'h0030 ? WIN : 0;
          busy <= (a == 20'h00555 && d == 16'h0010) ? 300 : 0;
          if (a == 20'h00555 && d == 16'h0010) mem = '{default: 16'hffff};
        end
        4'h7:
        begin
          if (d == 16'h0030) sel[a[19:12]] = 1'b1;
          win <= d == 16'h0030 ? WIN : 0;
          st <= d == 16'h0030 ? 4'h7 : 4'h0;
          susp <= d == 16'h00b0;
          ers <= d == 16'h00b0 ? 150 : 0;
          if (d != 16'h0030 && d != 16'h00b0) sel = '0;
        end
        4'h8: st <= d == 16'h00a0 ? 4'h9 : d == 16'h0090 ? 4'ha : 4'h8;
        4'ha: st <= d == 16'h0000 ? 4'h0 : 4'h8;
        default: st <= 4'h0;
      endcase
    end
    if (!pins.resetN)
    begin
      st <= 4'h0;
      susp <= 1'b0;
      busy <= 0;
      win <= 0;
      ers <= 0;
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import fcmd_pkg::*;
();
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdata;
  fcmd_pins_t  flashPins;
  logic [15:0] flashDqIn;
  logic        readyBusy;
  logic [31:0] lfsr = 32'h29a5;
  logic [19:0] pa;
  logic [7:0]  sec;
  logic [15:0] em [logic [19:0]];
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;

  fcmd_host #(.WIN_CYC(200), .SUSP_CYC(20)) fcmd_host_inst (.mclk(mclk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .flashPins(flashPins), .flashDqIn(flashDqIn), .readyBusy(readyBusy));
  fcmd_flash #(.WIN(200)) fcmd_flash_inst (.mclk(mclk), .pins(flashPins), .dqOut(flashDqIn),
    .readyBusy(readyBusy));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] cur(input logic [19:0] a);
    return em.exists(a) ? em[a] : 16'hffff;
  endfunction
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic sts(input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] s;
    rd(REG_STATUS, s);
    chk(nm, e, s & m);
  endtask
  // Bounded poll of 4000 status reads; it gives up long before the global cycle limit.
  task automatic hold(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] s;
    s = ~e;
    for (int i = 0; i < 4000 && (s & m) !== e; i++) rd(REG_STATUS, s);
  endtask
  task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
    wr(REG_ADDR, {12'h0, a});
    wr(REG_DATA, {16'h0, d});
    wr(REG_CTRL, {28'h0, c});
  endtask
  task automatic pw(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
    op(c, a, d);
    em[a] = cur(a) & d;
    hold(32'h13, 32'h02);
  endtask
  task automatic rdf(input logic [19:0] a, input logic [15:0] e);
    logic [31:0] v;
    op(OP_READ, a, 16'h0);
    hold(32'h01, 32'h00);
    rd(REG_RDATA, v);
    chk("flash word", {16'h0, e}, {16'h0, v[15:0]});
  endtask
  task automatic verify();
    foreach (em[k]) rdf(k, em[k]);
  endtask

  initial
  begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    wr(4'h2, 32'hffffffff);
    sts(32'hff, 32'h02, "status after reset");
    $display("Test reset done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      pa = {lfsr[7:0], 8'h00, lfsr[11:8]};
      pw(OP_PROGRAM, pa, lfsr[31:16]);
    end
    op(OP_PROGRAM, pa, 16'h0f0f);
    op(OP_READ, pa, 16'h0);
    sts(32'h40, 32'h40, "busy refusal");
    wr(REG_STATUS, 32'hc0);
    em[pa] = cur(pa) & 16'h0f0f;
    hold(32'h13, 32'h02);
    verify();
    op(OP_BYP_ENT, 20'h0, 16'h0);
    hold(32'h13, 32'h02);
    sts(32'h04, 32'h04, "bypass flag");
    for (int i = 0; i < 2; i++)
    begin
      lfsr = lfsr_next(lfsr);
      pw(OP_BYP_PROG, {lfsr[7:0], 8'h00, lfsr[11:8]}, lfsr[31:16]);
    end
    op(OP_PROGRAM, pa, 16'h0);
    sts(32'h40, 32'h40, "bypass refusal");
    wr(REG_STATUS, 32'hc0);
    op(OP_BYP_EXIT, 20'h0, 16'h0);
    hold(32'h13, 32'h02);
    sts(32'h04, 32'h00, "bypass exit");
    op(OP_RESET, 20'h0, 16'h0);
    hold(32'h13, 32'h02);
    verify();
    $display("Test program done");
    sec = pa[19:12];
    op(OP_SECT_ER, {sec, 12'h0}, 16'h0);
    hold(32'h01, 32'h00);
    sts(32'h10, 32'h10, "window open");
    op(OP_SECT_ADD, {sec ^ 8'h80, 12'h0}, 16'h0);
    hold(32'h01, 32'h00);
    op(OP_SUSPEND, 20'h0, 16'h0);
    hold(32'h01, 32'h00);
    sts(32'h38, 32'h28, "suspended");
    pw(OP_PROGRAM, {sec ^ 8'h01, 12'h00c}, 16'h5a5a);
    rdf({sec ^ 8'h01, 12'h00c}, cur({sec ^ 8'h01, 12'h00c}));
    op(OP_RESUME, 20'h0, 16'h0);
    hold(32'h01, 32'h00);
    op(OP_RESUME, 20'h0, 16'h0);
    sts(32'h40, 32'h40, "second resume");
    wr(REG_STATUS, 32'hc0);
    hold(32'h13, 32'h02);
    foreach (em[k]) if (k[19:12] == sec || k[19:12] == (sec ^ 8'h80)) em[k] = 16'hffff;
    verify();
    $display("Test sector erase done");
    op(OP_CHIP_ER, 20'h0, 16'h0);
    hold(32'h01, 32'h00);
    op(OP_SUSPEND, 20'h0, 16'h0);
    sts(32'h48, 32'h40, "chip erase busy");
    wr(REG_STATUS, 32'hc0);
    hold(32'h13, 32'h02);
    foreach (em[k]) em[k] = 16'hffff;
    verify();
    $display("Test chip erase done");
    lfsr = lfsr_next(lfsr);
    pa = {lfsr[7:0], 8'h00, lfsr[11:8]};
    op(OP_PROGRAM, pa, 16'h00ff);
    hold(32'h01, 32'h00);
    op(OP_HWRESET, 20'h0, 16'h0);
    hold(32'h01, 32'h00);
    sts(32'h80, 32'h80, "reset hit busy");
    wr(REG_STATUS, 32'hc0);
    pw(OP_PROGRAM, pa, 16'h00ff);
    rdf(pa, cur(pa));
    $display("Test hardware reset done");
    report_and_stop();
  end
endmodule
